// ===== utfr_consts.vh
/*
 Shared constants for the under-temperature fault response block.
 Assumes inclusion by bare name from the design files of this block.
*/
// Summary of operation
// - A 16-bit signed under-temperature threshold is writable and readable by the host.
// - Every action code pulls the alert line low and sets the fault status flag on a fault.
// - Action 00 keeps the output regulating with no interruption.
// - Action 01 keeps running for delay times 80 ms, then applies the retry setting if faulted.
// - Action 10 disables the output at once, then applies the retry setting.
// - Action 11 keeps the output off while the fault lasts and re-enables it after.
// - Retry 000 makes no restart and keeps the output off until the fault clears.
// - Retry 001 to 110 makes that many restarts, then stays off until the fault clears.
// - Restart attempts are spaced start to start by delay times 32 ms.
// - Retry 111 restarts without limit until commanded off or another fault shuts down.
// - The continue-operating delay is the delay count times 80 ms.
// - The delay field value is used directly as a count of 0 to 7 units.
`ifndef UTFR_CONSTS_VH
`define UTFR_CONSTS_VH

// ****************************************
// Command codes
// ****************************************
`define UTFR_CODE_THRESHOLD 8'h53
`define UTFR_CODE_ACTION 8'h54

// ****************************************
// Reset values
// ****************************************
`define UTFR_THRESHOLD_RST 16'h8000
`define UTFR_ACTION_RST 8'h00

// ****************************************
// Action register fields
// ****************************************
`define UTFR_MODE_HI 7
`define UTFR_MODE_LO 6
`define UTFR_RETRY_HI 5
`define UTFR_RETRY_LO 3
`define UTFR_DELAY_HI 2
`define UTFR_DELAY_LO 0

`define UTFR_MODE_IGNORE 2'h0
`define UTFR_MODE_DELAY 2'h1
`define UTFR_MODE_DISABLE 2'h2
`define UTFR_MODE_UNTIL_CLEAR 2'h3
`define UTFR_RETRY_NONE 3'h0
`define UTFR_RETRY_FOREVER 3'h7

// ****************************************
// Timing
// ****************************************
`define UTFR_CLK_MHZ 100
`define UTFR_OPER_UNIT_MS 80
`define UTFR_RETRY_UNIT_MS 32
`define UTFR_CYC_PER_MS (`UTFR_CLK_MHZ * 1000)
`define UTFR_OPER_UNIT_CYC (`UTFR_OPER_UNIT_MS * `UTFR_CYC_PER_MS)
`define UTFR_RETRY_UNIT_CYC (`UTFR_RETRY_UNIT_MS * `UTFR_CYC_PER_MS)

`endif

// ===== utfr_host.sv
/*
 Host-side command model for utfr_undertemp: register writes and reads.
 Assumes a protocol engine turns each bus transfer into one command pulse.
*/
`timescale 1ns/100ps
module utfr_host (
   input wire clk,
   output reg cmd_valid,
   output reg cmd_write,
   output reg [7:0] cmd_code,
   output reg [15:0] cmd_wdata,
   input wire rd_valid,
   input wire [15:0] rd_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // One pulse, fields held to the taking edge, then data (write) or code (read) scrambled
   // One idle edge closes each command, so valid never toggles twice at once
   task wr(input [7:0] code, input [15:0] data);
      begin
         cmd_code = code;
         cmd_wdata = data;
         cmd_write = 1'b1;
         cmd_valid = 1'b1;
         @(posedge clk);
         #1;
         cmd_valid = 1'b0;
         cmd_wdata = ~data;
         @(posedge clk);
         #1;
      end
   endtask
   task rd(input [7:0] code, output [15:0] data);
      begin
         cmd_code = code;
         cmd_write = 1'b0;
         cmd_valid = 1'b1;
         @(posedge clk);
         #1;
         cmd_valid = 1'b0;
         cmd_code = ~code;
         data = rd_valid ? rd_data : 16'hxxxx;
         @(posedge clk);
         #1;
      end
   endtask
endmodule // utfr_host

// ===== utfr_timer.v
/*
 Unit-based delay timer: counts a number of units of a given cycle length.
 Assumes start, clear and unit length come from logic on the same clock.
*/
`timescale 1ns/100ps
module utfr_timer #(
   parameter CW = 24
) (
   input wire clk,
   input wire srst,
   input wire start,
   input wire clear,
   input wire [2:0] units,
   input wire [CW-1:0] unit_cycles,
   output wire done
);
   reg run_q;
   reg [2:0] left_q;
   reg [CW-1:0] cyc_q;
   reg done_q;

   // ****************************************
   // Unit and cycle counters
   // ****************************************
   always @(posedge clk) begin
      done_q <= 1'b0;
      if (srst || clear) begin
         run_q <= 1'b0;
         left_q <= 3'h0;
         cyc_q <= {CW{1'b0}};
      end else if (start) begin
         if (units == 3'h0) begin
            done_q <= 1'b1;
            run_q <= 1'b0;
         end else begin
            run_q <= 1'b1;
            left_q <= units;
            cyc_q <= unit_cycles - {{(CW-1){1'b0}}, 1'b1};
         end
      end else if (run_q) begin
         if (cyc_q != {CW{1'b0}}) begin
            cyc_q <= cyc_q - {{(CW-1){1'b0}}, 1'b1};
         end else if (left_q == 3'h1) begin
            run_q <= 1'b0;
            done_q <= 1'b1;
         end else begin
            left_q <= left_q - 3'h1;
            cyc_q <= unit_cycles - {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end

   assign done = done_q;
endmodule // utfr_timer

// ===== utfr_undertemp.v
/*
 Under-temperature fault response: threshold and action registers reached by
 command code, fault detection, alert and output enable sequencing.
 Assumes the bus protocol engine and the temperature measurement run on clk;
 the enable pin arrives asynchronously.
*/
`timescale 1ns/100ps
`include "utfr_consts.vh"
module utfr_undertemp #(
   parameter CW = 24,
   parameter [CW-1:0] OPER_UNIT_CYC = `UTFR_OPER_UNIT_CYC,
   parameter [CW-1:0] RETRY_UNIT_CYC = `UTFR_RETRY_UNIT_CYC
) (
   input wire clk,
   input wire srst,
   input wire cmd_valid,
   input wire cmd_write,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   output wire cmd_hit,
   output reg [15:0] rd_data,
   output reg rd_valid,
   input wire [15:0] temp_reading,
   input wire enable_pin,
   input wire other_fault_off,
   input wire clear_faults,
   output wire ut_fault_flag,
   output wire bus_alert_line_o,
   output wire bus_alert_line_oe,
   output wire output_enable,
   output wire [2:0] state_out
);
   localparam [2:0] ST_RUN = 3'h0;
   localparam [2:0] ST_DELAY = 3'h1;
   localparam [2:0] ST_WAIT = 3'h2;
   localparam [2:0] ST_ATTEMPT = 3'h3;
   localparam [2:0] ST_LATCH = 3'h4;

   reg [15:0] threshold_q;
   reg [7:0] action_q;
   reg en_meta_q;
   reg en_sync_q;
   reg fault_q;
   reg flag_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [2:0] att_q;
   reg [2:0] att_d;
   reg oe_q;
   reg tmr_start;
   reg tmr_long;
   wire tmr_done;
   wire fault_now;
   wire fault_rise;
   wire run_cmd;
   wire [1:0] mode;
   wire [2:0] retry;
   wire [2:0] delay;
   wire hit_thr;
   wire hit_act;

   assign mode = action_q[`UTFR_MODE_HI:`UTFR_MODE_LO];
   assign retry = action_q[`UTFR_RETRY_HI:`UTFR_RETRY_LO];
   assign delay = action_q[`UTFR_DELAY_HI:`UTFR_DELAY_LO];

   // ****************************************
   // Registers by command code
   // ****************************************
   assign hit_thr = cmd_code == `UTFR_CODE_THRESHOLD;
   assign hit_act = cmd_code == `UTFR_CODE_ACTION;
   assign cmd_hit = cmd_valid & (hit_thr | hit_act);

   always @(posedge clk) begin
      if (srst) begin
         threshold_q <= `UTFR_THRESHOLD_RST;
         action_q <= `UTFR_ACTION_RST;
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= cmd_valid & ~cmd_write;
         if (cmd_valid && cmd_write && hit_thr) begin
            threshold_q <= cmd_wdata;
         end
         if (cmd_valid && cmd_write && hit_act) begin
            action_q <= cmd_wdata[7:0];
         end
         if (cmd_valid && !cmd_write) begin
            if (hit_thr) begin
               rd_data <= threshold_q;
            end else if (hit_act) begin
               rd_data <= {8'h00, action_q};
            end else begin
               rd_data <= 16'h0000;
            end
         end
      end
   end

   // ****************************************
   // Pin sync, fault detect, status flag
   // ****************************************
   assign fault_now = $signed(temp_reading) < $signed(threshold_q);
   assign fault_rise = fault_now & ~fault_q;
   assign run_cmd = en_sync_q & ~other_fault_off;

   always @(posedge clk) begin
      if (srst) begin
         en_meta_q <= 1'b0;
         en_sync_q <= 1'b0;
         fault_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         en_meta_q <= enable_pin;
         en_sync_q <= en_meta_q;
         fault_q <= fault_now;
         if (fault_rise) begin
            flag_q <= 1'b1;
         end else if (clear_faults) begin
            flag_q <= 1'b0;
         end
      end
   end

   assign ut_fault_flag = flag_q;
   assign bus_alert_line_o = 1'b0;
   assign bus_alert_line_oe = flag_q;

   // ****************************************
   // Response timer
   // ****************************************
   utfr_timer #(
      .CW(CW)
   ) u_timer (
      .clk(clk),
      .srst(srst),
      .start(tmr_start),
      .clear(~fault_q | ~run_cmd),
      .units(delay),
      .unit_cycles(tmr_long ? OPER_UNIT_CYC : RETRY_UNIT_CYC),
      .done(tmr_done)
   );

   // ****************************************
   // Response state machine
   // ****************************************
   always @* begin
      state_d = state_q;
      att_d = att_q;
      tmr_start = 1'b0;
      tmr_long = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (fault_q && run_cmd) begin
               case (mode)
                  `UTFR_MODE_IGNORE: state_d = ST_RUN;
                  `UTFR_MODE_DELAY: begin
                     state_d = ST_DELAY;
                     tmr_start = 1'b1;
                     tmr_long = 1'b1;
                  end
                  `UTFR_MODE_DISABLE: begin
                     if (retry == `UTFR_RETRY_NONE) begin
                        state_d = ST_LATCH;
                     end else begin
                        state_d = ST_WAIT;
                        tmr_start = 1'b1;
                     end
                  end
                  default: state_d = ST_LATCH;
               endcase
            end
         end
         ST_DELAY: begin
            tmr_long = 1'b1;
            if (tmr_done) begin
               if (retry == `UTFR_RETRY_NONE) begin
                  state_d = ST_LATCH;
               end else begin
                  state_d = ST_WAIT;
                  tmr_start = 1'b1;
                  tmr_long = 1'b0;
               end
            end
         end
         ST_WAIT: begin
            if (tmr_done) begin
               if (retry == `UTFR_RETRY_FOREVER || att_q < retry) begin
                  state_d = ST_ATTEMPT;
               end else begin
                  state_d = ST_LATCH;
               end
            end
         end
         ST_ATTEMPT: begin
            state_d = ST_WAIT;
            tmr_start = 1'b1;
            if (retry != `UTFR_RETRY_FOREVER) begin
               att_d = att_q + 3'h1;
            end
         end
         ST_LATCH: state_d = ST_LATCH;
         default: state_d = ST_RUN;
      endcase
      if (!fault_q || !run_cmd) begin
         state_d = ST_RUN;
         att_d = 3'h0;
         tmr_start = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         state_q <= ST_RUN;
         att_q <= 3'h0;
         oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         att_q <= att_d;
         oe_q <= run_cmd && (state_d == ST_RUN || state_d == ST_DELAY
                             || state_d == ST_ATTEMPT);
      end
   end

   assign output_enable = oe_q;
   assign state_out = state_q;
endmodule // utfr_undertemp

// ===== utfr_undertemp_properties.sv
/*
 Checker for utfr_undertemp port timing.
 Assumes all watched inputs are synchronous to clk.
*/
`timescale 1ns/100ps
module utfr_props #(
   parameter CW = 24,
   parameter [CW-1:0] OPER_UNIT_CYC = 20,
   parameter [CW-1:0] RETRY_UNIT_CYC = 8
) (
   input wire clk,
   input wire srst,
   input wire cmd_valid,
   input wire cmd_write,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   input wire cmd_hit,
   input wire rd_valid,
   input wire [15:0] temp_reading,
   input wire other_fault_off,
   input wire ut_fault_flag,
   input wire bus_alert_line_o,
   input wire bus_alert_line_oe,
   input wire output_enable,
   input wire [2:0] state_out
);
   reg [15:0] thr_q;
   reg [7:0] act_q;
   reg fq_q;
   reg [CW+3:0] w_q;
   always @(posedge clk) begin
      if (srst) thr_q <= 16'h8000;
      else if (cmd_valid && cmd_write && cmd_code == 8'h53) thr_q <= cmd_wdata;
      if (srst) act_q <= 8'h00;
      else if (cmd_valid && cmd_write && cmd_code == 8'h54) act_q <= cmd_wdata[7:0];
      fq_q <= !srst && ($signed(temp_reading) < $signed(thr_q));
      w_q <= (state_out == 3'h2) ? w_q + 1'b1 : {(CW+4){1'b0}};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_read_answer: assert property (cmd_valid && !cmd_write |=> rd_valid)
      else $error("read not answered");
   a_hit_decode: assert property (cmd_hit == (cmd_valid &&
      (cmd_code == 8'h53 || cmd_code == 8'h54))) else $error("hit decode wrong");
   a_alert_follow: assert property (bus_alert_line_oe == ut_fault_flag && !bus_alert_line_o)
      else $error("alert not tracking flag");
   a_fault_flags: assert property ($signed(temp_reading) < $signed(thr_q) |=> ut_fault_flag)
      else $error("fault flag missed");
   a_wait_off: assert property (state_out == 3'h2 || state_out == 3'h4 |-> !output_enable)
      else $error("output on while off");
   a_retry_space: assert property (state_out == 3'h3 && $past(state_out) == 3'h2
      |-> w_q == act_q[2:0] * RETRY_UNIT_CYC + 1'b1) else $error("retry spacing wrong");
   a_clear_runs: assert property (!fq_q |=> state_out == 3'h0)
      else $error("no return to run");
   a_cmd_off: assert property (other_fault_off |=> state_out == 3'h0 && !output_enable)
      else $error("off command ignored");
   c_attempt: cover property (state_out == 3'h3);
   c_latched: cover property (state_out == 3'h4);
   c_delay: cover property (state_out == 3'h1 ##1 state_out == 3'h2);
endmodule // utfr_props
bind utfr_undertemp utfr_props #(.CW(CW), .OPER_UNIT_CYC(OPER_UNIT_CYC),
   .RETRY_UNIT_CYC(RETRY_UNIT_CYC)) utfr_props_i (
   .clk(clk),
   .srst(srst),
   .cmd_valid(cmd_valid),
   .cmd_write(cmd_write),
   .cmd_code(cmd_code),
   .cmd_wdata(cmd_wdata),
   .cmd_hit(cmd_hit),
   .rd_valid(rd_valid),
   .temp_reading(temp_reading),
   .other_fault_off(other_fault_off),
   .ut_fault_flag(ut_fault_flag),
   .bus_alert_line_o(bus_alert_line_o),
   .bus_alert_line_oe(bus_alert_line_oe),
   .output_enable(output_enable),
   .state_out(state_out));

// ===== utfr_undertemp_test.sv
/*
 Testbench for utfr_undertemp: registers and every response mode.
 Assumes short timing units of 20 and 8 cycles.
*/
`timescale 1ns/100ps
module utfr_undertemp_test;
   reg clk = 1'b0;
   reg srst = 1'b1;
   reg [15:0] temp_reading = 16'h0040;
   reg enable_pin = 1'b0;
   reg other_fault_off = 1'b0;
   reg clear_faults = 1'b0;
   wire cmd_valid, cmd_write, cmd_hit, rd_valid, ut_fault_flag, output_enable;
   wire bus_alert_line_o, bus_alert_line_oe;
   wire [7:0] cmd_code;
   wire [15:0] cmd_wdata, rd_data;
   wire [2:0] state_out;
   integer fail_count = 0, samples_checked = 0, cyc = 0, n_att, n_dly, i;
   reg [15:0] rv;
   always #5 clk = ~clk;
   utfr_host utfr_host_i (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data));
   utfr_undertemp #(.OPER_UNIT_CYC(24'd20), .RETRY_UNIT_CYC(24'd8)) utfr_undertemp_i (
      .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_hit(cmd_hit), .rd_data(rd_data),
      .rd_valid(rd_valid), .temp_reading(temp_reading), .enable_pin(enable_pin),
      .other_fault_off(other_fault_off), .clear_faults(clear_faults),
      .ut_fault_flag(ut_fault_flag), .bus_alert_line_o(bus_alert_line_o),
      .bus_alert_line_oe(bus_alert_line_oe), .output_enable(output_enable),
      .state_out(state_out));
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   // Fault under one setting; count attempt and delay cycles
   task run_case(input [7:0] act, input integer lim, input [7:0] e_att, input [7:0] e_dly,
      input e_oe);
      begin
         utfr_host_i.wr(8'h54, {8'h00, act});
         temp_reading = 16'hfff0;
         n_att = 0;
         n_dly = 0;
         for (i = 0; i < lim && state_out !== 3'h4; i = i + 1) begin
            tick(1);
            n_att = n_att + (state_out === 3'h3);
            n_dly = n_dly + (state_out === 3'h1);
         end
         chk(ut_fault_flag, 1'b1);
         chk(bus_alert_line_oe, 1'b1);
         chk(n_att[7:0], e_att);
         chk(n_dly[7:0], e_dly);
         chk(output_enable, e_oe);
         temp_reading = 16'h0040;
         tick(2);
         clear_faults = 1'b1;
         tick(1);
         clear_faults = 1'b0;
         tick(2);
         chk(output_enable, 1'b1);
         chk(ut_fault_flag, 1'b0);
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         print_verdict;
      end
   end
   initial begin
      tick(8);
      srst = 1'b0;
      utfr_host_i.rd(8'h53, rv);
      chk(rv, 16'h8000);
      utfr_host_i.rd(8'h54, rv);
      chk(rv, 16'h0000);
      utfr_host_i.wr(8'h53, 16'h0010);
      utfr_host_i.wr(8'h54, 16'h00a5);
      utfr_host_i.rd(8'h53, rv);
      chk(rv, 16'h0010);
      utfr_host_i.rd(8'h54, rv);
      chk(rv, 16'h00a5);
      utfr_host_i.rd(8'h60, rv);
      chk(rv, 16'h0000);
      enable_pin = 1'b1;
      tick(5);
      chk(output_enable, 1'b1);
      run_case(8'h00, 30, 0, 0, 1'b1);
      run_case(8'h49, 300, 1, 21, 1'b0);
      run_case(8'h42, 300, 0, 41, 1'b0);
      run_case(8'h82, 30, 0, 0, 1'b0);
      run_case(8'h93, 300, 2, 0, 1'b0);
      run_case(8'hb0, 300, 6, 0, 1'b0);
      run_case(8'hc9, 30, 0, 0, 1'b0);
      run_case(8'hb9, 200, 19, 0, 1'b0);
      // Endless retry stopped by another fault shutting the output down
      utfr_host_i.wr(8'h54, 16'h00b9);
      temp_reading = 16'hfff0;
      tick(15);
      other_fault_off = 1'b1;
      tick(1);
      chk(output_enable, 1'b0);
      chk(state_out, 3'h0);
      temp_reading = 16'h0040;
      tick(2);
      other_fault_off = 1'b0;
      tick(3);
      chk(output_enable, 1'b1);
      chk(ut_fault_flag, 1'b1);
      print_verdict;
   end
endmodule // utfr_undertemp_test
